// ===== tb/operation_mode_selector_tb.sv
// Testbench for the operation mode selector over its register bus.
// Assumes the switch model on the terminals and the checker bound below.
`timescale 1ns/100ps
module operation_mode_selector_tb;
    import opmode_pkg::*;
    logic mclk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, activeMode, resp;
    logic fwdStartN, revStartN, motorRunning, speedRefPresent, freqFromPanel;
    logic startFromPanel, runFwd, runRev, fwdClose, revClose, holdRun;
    int n_errors = 0;
    int checked = 0;
    typedef struct {logic [3:0] v; logic [1:0] r; logic [3:0] b; logic c;
        logic [1:0] m; logic f; logic s;} row_t;
    // Selection value, response, read back, mode checked, mode, sources.
    row_t rows [11] = '{'{4'h0, AXI_OKAY, 4'h0, 1, MODE_EXTERNAL, 0, 0},
        '{4'h1, AXI_OKAY, 4'h1, 1, MODE_PANEL, 1, 1}, '{4'h2, AXI_OKAY, 4'h2, 1, MODE_EXTERNAL, 0, 0},
        '{4'h3, AXI_OKAY, 4'h3, 1, MODE_COMBINED, 1, 0},
        '{4'h4, AXI_OKAY, 4'h4, 1, MODE_COMBINED, 0, 1},
        '{4'h5, AXI_SLVERR, 4'h4, 1, MODE_COMBINED, 0, 1},
        '{4'h9, AXI_SLVERR, 4'h4, 1, MODE_COMBINED, 0, 1},
        '{4'h6, AXI_OKAY, 4'h6, 0, MODE_EXTERNAL, 0, 0}, '{4'h7, AXI_OKAY, 4'h7, 1, MODE_EXTERNAL, 0, 0},
        '{4'h8, AXI_OKAY, 4'h8, 0, MODE_EXTERNAL, 0, 0}, '{4'hF, AXI_SLVERR, 4'h8, 0, MODE_EXTERNAL, 0, 0}};

    operation_mode_selector operation_mode_selector_i (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fwdStartN, .revStartN, .motorRunning,
        .speedRefPresent, .freqFromPanel, .startFromPanel, .runFwd, .runRev, .activeMode);
    start_switch_model start_switch_model_i (.mclk, .fwdClose, .revClose, .holdRun, .runFwd,
        .runRev, .fwdStartN, .revStartN, .motorRunning);

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Write: address and data offered together, each dropped once taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdreg(input logic [3:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Mode changes land within a few edges of the write.
    task automatic sel(input logic [3:0] v);
        wr(ADDR_MODE_SELECT, {28'h000_0000, v});
        repeat (3) @(posedge mclk);
    endtask
    task automatic key(input int b);
        wr(ADDR_KEYS, 32'h0000_0001 << b);
        repeat (3) @(posedge mclk);
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // A hang ends the run well beyond the few hundred cycles the tests need.
    initial begin
        #500000;
        n_errors++;
        stop_test();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {srst, speedRefPresent} = 2'b11;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {fwdClose, revClose, holdRun} = 3'b000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {12'h00F, 32'h0000_0000};
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        rdreg(ADDR_MODE_SELECT);
        chk(rd, 32'h0000_0000);
        chk(activeMode, MODE_EXTERNAL);
        foreach (rows[i]) begin
            sel(rows[i].v);
            chk(resp, rows[i].r);
            rdreg(ADDR_MODE_SELECT);
            chk(rd, {28'h000_0000, rows[i].b});
            if (rows[i].c) begin
                chk(activeMode, rows[i].m);
                chk({freqFromPanel, startFromPanel}, {rows[i].f, rows[i].s});
            end
        end
        // External start with and without a speed reference.
        sel(SEL_SELECTABLE);
        fwdClose <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(runFwd, 1'b1);
        speedRefPresent <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(runFwd, 1'b0);
        key(KEY_PANEL_BIT);
        chk(activeMode, MODE_EXTERNAL);
        rdreg(ADDR_STATUS);
        chk(rd[ST_REJECT_BIT], 1'b1);
        {fwdClose, speedRefPresent, holdRun} <= 3'b011;
        key(KEY_PANEL_BIT);
        chk(activeMode, MODE_EXTERNAL);
        holdRun <= 1'b0;
        key(KEY_PANEL_BIT);
        chk(activeMode, MODE_PANEL);
        // A lit run lamp blocks the return to external mode; no speed keeps the motor still.
        speedRefPresent <= 1'b0;
        key(KEY_FWD_BIT);
        key(KEY_EXT_BIT);
        chk(activeMode, MODE_PANEL);
        key(KEY_STOP_BIT);
        speedRefPresent <= 1'b1;
        key(KEY_EXT_BIT);
        chk(activeMode, MODE_EXTERNAL);
        sel(SEL_PANEL_ONLY);
        key(KEY_EXT_BIT);
        chk(activeMode, MODE_PANEL);
        sel(SEL_EXT_ONLY);
        key(KEY_PANEL_BIT);
        chk(activeMode, MODE_EXTERNAL);
        sel(SEL_SWITCH_OVER);
        holdRun <= 1'b1;
        key(KEY_PANEL_BIT);
        chk(activeMode, MODE_PANEL);
        holdRun <= 1'b0;
        // External switch signal picks the mode when the value is 8.
        sel(SEL_EXT_SIGNAL);
        key(KEY_STOP_BIT);
        chk(activeMode, MODE_EXTERNAL);
        key(KEY_SIGNAL_BIT);
        chk(activeMode, MODE_PANEL);
        // Value 4 takes its start from the panel reverse key.
        sel(SEL_COMBO_PANEL_START);
        key(KEY_REV_BIT);
        chk(runRev, 1'b1);
        key(KEY_STOP_BIT);
        chk(runRev, 1'b0);
        // Unmapped address is refused both ways.
        rdreg(4'hC);
        chk(resp, AXI_SLVERR);
        chk(rd, 32'h0000_0000);
        wr(4'hC, 32'h0000_0001);
        chk(resp, AXI_SLVERR);
        // A second reset in mid-run restores the default.
        sel(SEL_PANEL_ONLY);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rdreg(ADDR_MODE_SELECT);
        chk(rd, 32'h0000_0000);
        chk(activeMode, MODE_EXTERNAL);
        stop_test();
    end
endmodule

bind operation_mode_selector opmode_sel_chk opmode_sel_chk_i (.mclk, .srst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .fwdStartN, .revStartN, .speedRefPresent, .freqFromPanel, .startFromPanel,
    .runFwd, .runRev, .activeMode);

// ===== tb/opmode_sel_chk.sv
// Checker for the operation mode selector: bus timing and mode outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module opmode_sel_chk
    import opmode_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Terminals and drive side
    input wire logic fwdStartN,
    input wire logic revStartN,
    input wire logic speedRefPresent,
    input wire logic freqFromPanel,
    input wire logic startFromPanel,
    input wire logic runFwd,
    input wire logic runRev,
    input wire logic [1:0] activeMode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_reset_external: assert property (disable iff (1'b0)
        srst |=> activeMode == MODE_EXTERNAL && !freqFromPanel && !startFromPanel)
        else $error("mode not external after reset");
    // Answers stand until the master takes them.
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
        |=> s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_combo_sources: assert property (
        activeMode == MODE_COMBINED |-> freqFromPanel != startFromPanel)
        else $error("combined sources wrong");
    // closed forward terminal runs in external mode.
    a_external_run: assert property (
        (activeMode == MODE_EXTERNAL && !fwdStartN && revStartN && speedRefPresent)[*5]
        |-> runFwd) else $error("external start ignored");
    a_run_exclusive: assert property (!(runFwd && runRev)) else $error("both directions run");
endmodule

// ===== tb/start_switch_model.sv
// Far side model: start switches on the terminals and the running motor.
// Assumes the bench commands the switches on mclk edges.
`timescale 1ns/100ps
module start_switch_model (
    // Clock
    input wire logic mclk,
    // Commands from the bench
    input wire logic fwdClose,
    input wire logic revClose,
    input wire logic holdRun,
    // Run command from the selector
    input wire logic runFwd,
    input wire logic runRev,
    // Terminals, pulled up when open, and the motor state
    output logic fwdStartN,
    output logic revStartN,
    output logic motorRunning
);
    // An open switch leaves the pulled-up terminal high.
    assign fwdStartN = !fwdClose;
    assign revStartN = !revClose;
    // The motor turns a cycle after a run command; holdRun models coasting.
    always @(posedge mclk) begin
        motorRunning <= runFwd | runRev | holdRun;
    end
endmodule

// ===== verilog/operation_mode_selector.sv
// Operation mode selector: chooses frequency and start sources for the drive.
// Assumes an AXI4-Lite master on mclk and raw start terminals from the field.
// What this block does
// - Reset enters external mode when the selection holds its default.
// - External mode runs when a start terminal is closed to the common.
// - Panel key in external mode with no start input selects panel mode.
// - External key in panel mode needs starts off and both run lamps dark.
// - Value 3: panel sets frequency, start terminals give the start.
// - Value 4: terminals set frequency, panel forward and reverse give the start.
// - Value 0 lets the keys choose between panel and external mode.
// - Value 1 fixes panel mode and refuses every change.
// - Value 2 fixes external mode and refuses every change.
// - Values 6, 7 and 8 select switch-over, edit-enable and signal switching.
// - No key or signal mode change while an external start command is active.
// - Values 1 to 4 and 7 fix the mode from the value, not the keys.
// - Default value: external at power-up, panel key still reaches panel.
// - Mode keys are ignored while the motor runs, except with value 6.
// - Mode keys are ignored for values 1 to 4, 7 and 8.
`timescale 1ns/100ps
module operation_mode_selector
    import opmode_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Start terminals, low when closed to the input common
    input wire logic fwdStartN,
    input wire logic revStartN,
    // Drive status
    input wire logic motorRunning,
    input wire logic speedRefPresent,
    // Source selection and run command to the drive
    output logic freqFromPanel,
    output logic startFromPanel,
    output logic runFwd,
    output logic runRev,
    output logic [1:0] activeMode
);

    // ************************************************************
    // Start terminal synchroniser
    // ************************************************************
    start_sync_if startSync();

    start_input_sync u_sync (
        .mclk(mclk),
        .srst(srst),
        .fwdStartN(fwdStartN),
        .revStartN(revStartN),
        .syncOut(startSync.src)
    );

    // ************************************************************
    // Register state
    // ************************************************************
    logic [3:0] modeSel_r;
    opMode_t mode_r;
    opMode_t mode_nxt;
    logic fwdLamp_r;
    logic revLamp_r;
    logic reject_r;
    logic awHeld_r;
    logic wHeld_r;
    logic [3:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;

    // Valid codes: 0-4 and 6-8; 5 and 9-15 are refused.
    function automatic logic sel_valid(input logic [3:0] v);
        sel_valid = (v <= SEL_COMBO_PANEL_START) ||
                    ((v >= SEL_SWITCH_OVER) && (v <= SEL_EXT_SIGNAL));
    endfunction

    // Fixed mode implied by the selection value for the fixed settings.
    function automatic opMode_t fixed_mode(input logic [3:0] v);
        if (v == SEL_PANEL_ONLY) begin
            fixed_mode = MODE_PANEL;
        end else if ((v == SEL_COMBO_PANEL_FREQ) || (v == SEL_COMBO_PANEL_START)) begin
            fixed_mode = MODE_COMBINED;
        end else begin
            fixed_mode = MODE_EXTERNAL;
        end
    endfunction

    // ************************************************************
    // AXI4-Lite write path
    // ************************************************************
    // Address and data are latched separately so they may arrive in any order.
    wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    wire wrFull = (wStrb_r[0] == 1'b1);
    wire wrSelAddr = (awAddr_r == ADDR_MODE_SELECT);
    wire wrKeyAddr = (awAddr_r == ADDR_KEYS);
    wire wrMapped = wrSelAddr || wrKeyAddr;
    wire [3:0] wrSelVal = wData_r[3:0];
    wire wrSelOk = wrSelAddr && wrFull && sel_valid(wrSelVal);
    wire wrOk = wrSelOk || (wrKeyAddr && wrFull);
    wire keyStrobe = doWrite && wrKeyAddr && wrFull;
    wire keyPanel = keyStrobe && wData_r[KEY_PANEL_BIT];
    wire keyExt = keyStrobe && wData_r[KEY_EXT_BIT];
    wire keyFwd = keyStrobe && wData_r[KEY_FWD_BIT];
    wire keyRev = keyStrobe && wData_r[KEY_REV_BIT];
    wire keyStop = keyStrobe && wData_r[KEY_STOP_BIT];
    wire keySignal = wData_r[KEY_SIGNAL_BIT];

    assign s_axi_awready = !awHeld_r;
    assign s_axi_wready = !wHeld_r;

    // Holding registers and write response.
    always_ff @(posedge mclk) begin
        if (srst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 4'h0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && !awHeld_r) begin
                awHeld_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && !wHeld_r) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrOk || !wrMapped) ? AXI_OKAY : AXI_SLVERR;
                if (!wrMapped) begin
                    s_axi_bresp <= AXI_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Selection value: a refused write keeps the old value.
    always_ff @(posedge mclk) begin
        if (srst) begin
            modeSel_r <= RESET_MODE_SELECT;
        end else if (doWrite && wrSelOk) begin
            modeSel_r <= wrSelVal;
        end
    end

    // ************************************************************
    // Mode decision
    // ************************************************************
    wire extStart = startSync.forward_run_key || startSync.reverse_run_key;
    wire lampsLit = fwdLamp_r || revLamp_r;
    wire keysAllowed = !motorRunning &&
                       ((modeSel_r == SEL_SELECTABLE) || (modeSel_r == SEL_SWITCH_OVER));
    // Switch-over also permits key changes while running.
    wire swOverAllowed = (modeSel_r == SEL_SWITCH_OVER);
    wire panelKeyAllowed = (modeSel_r == SEL_SELECTABLE) ? keysAllowed : swOverAllowed;
    wire keyChangeOk = panelKeyAllowed && !extStart;
    wire sigMode = (modeSel_r == SEL_EXT_SIGNAL);
    wire sigChangeOk = sigMode && !extStart && !motorRunning;
    wire anyModeKey = keyPanel || keyExt;

    // Next mode; everything not listed keeps the present mode.
    always_comb begin
        mode_nxt = mode_r;
        unique case (modeSel_r)
            SEL_SELECTABLE, SEL_SWITCH_OVER: begin
                if (keyPanel && keyChangeOk && mode_r == MODE_EXTERNAL) begin
                    mode_nxt = MODE_PANEL;
                end else if (keyExt && keyChangeOk && !lampsLit && mode_r == MODE_PANEL) begin
                    mode_nxt = MODE_EXTERNAL;
                end else if (mode_r == MODE_COMBINED) begin
                    mode_nxt = MODE_EXTERNAL;
                end
            end
            SEL_EXT_SIGNAL: begin
                if (sigChangeOk && keyStrobe) begin
                    mode_nxt = keySignal ? MODE_PANEL : MODE_EXTERNAL;
                end
            end
            default: begin
                mode_nxt = fixed_mode(modeSel_r);
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_r <= MODE_EXTERNAL;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Rejected mode request is sticky until a later accepted one.
    always_ff @(posedge mclk) begin
        if (srst) begin
            reject_r <= 1'b0;
        end else if (anyModeKey) begin
            reject_r <= (mode_nxt == mode_r);
        end
    end

    // ************************************************************
    // Source routing and run command
    // ************************************************************
    // panel frequency, terminal start
    // terminal frequency, panel start
    // Combined mode keeps its sources split even in the one cycle after a new selection lands.
    wire comboFreqPanel = (mode_r == MODE_COMBINED) && (modeSel_r != SEL_COMBO_PANEL_START);
    wire comboStartPanel = (mode_r == MODE_COMBINED) && (modeSel_r == SEL_COMBO_PANEL_START);
    wire freqPanel = (mode_r == MODE_PANEL) || comboFreqPanel;
    wire startPanel = (mode_r == MODE_PANEL) || comboStartPanel;

    // Panel run lamps follow the forward and reverse keys until stop.
    always_ff @(posedge mclk) begin
        if (srst) begin
            fwdLamp_r <= 1'b0;
            revLamp_r <= 1'b0;
        end else if (!startPanel || keyStop) begin
            fwdLamp_r <= 1'b0;
            revLamp_r <= 1'b0;
        end else if (keyFwd) begin
            fwdLamp_r <= 1'b1;
            revLamp_r <= 1'b0;
        end else if (keyRev) begin
            fwdLamp_r <= 1'b0;
            revLamp_r <= 1'b1;
        end
    end

    // terminal start runs
    // Both terminals closed together give no run, as a safe choice.
    wire termFwd = startSync.forward_run_key && !startSync.reverse_run_key;
    wire termRev = startSync.reverse_run_key && !startSync.forward_run_key;
    wire cmdFwd = startPanel ? fwdLamp_r : termFwd;
    wire cmdRev = startPanel ? revLamp_r : termRev;

    // Outputs registered; rotation also needs a speed reference.
    always_ff @(posedge mclk) begin
        if (srst) begin
            runFwd <= 1'b0;
            runRev <= 1'b0;
            freqFromPanel <= 1'b0;
            startFromPanel <= 1'b0;
            activeMode <= 2'b00;
        end else begin
            runFwd <= cmdFwd && speedRefPresent;
            runRev <= cmdRev && speedRefPresent;
            freqFromPanel <= freqPanel;
            startFromPanel <= startPanel;
            activeMode <= mode_r;
        end
    end

    // ************************************************************
    // AXI4-Lite read path
    // ************************************************************
    logic [31:0] statusWord;
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[ST_MODE_LSB +: 2] = mode_r;
        statusWord[ST_FREQ_PANEL_BIT] = freqPanel;
        statusWord[ST_START_PANEL_BIT] = startPanel;
        statusWord[ST_RUN_BIT] = motorRunning;
        statusWord[ST_FWD_LAMP_BIT] = fwdLamp_r;
        statusWord[ST_REV_LAMP_BIT] = revLamp_r;
        statusWord[ST_REJECT_BIT] = reject_r;
    end

    wire [3:0] rdAddr = {s_axi_araddr[3:2], 2'b00};
    wire rdSel = (rdAddr == ADDR_MODE_SELECT);
    wire rdStat = (rdAddr == ADDR_STATUS);
    wire rdKeys = (rdAddr == ADDR_KEYS);
    wire [31:0] rdWord = rdSel ? {28'h000_0000, modeSel_r} : (rdStat ? statusWord : 32'h0000_0000);
    assign s_axi_arready = !s_axi_rvalid;

    // One read at a time; the answer follows the address by one cycle.
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= (rdSel || rdStat || rdKeys) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== verilog/opmode_pkg.sv
// Package for the operation mode selector: register map, mode codes, reset values.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned registers.
package opmode_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_MODE_SELECT = 4'h0;   // operation_mode_select, RW.
    localparam logic [3:0] ADDR_STATUS = 4'h4;        // Live mode and sources, RO.
    localparam logic [3:0] ADDR_KEYS = 4'h8;          // Panel key requests, W pulses.
    localparam logic [3:0] RESET_MODE_SELECT = 4'h0;

    // Key register bits.
    localparam int KEY_PANEL_BIT = 0;
    localparam int KEY_EXT_BIT = 1;
    localparam int KEY_FWD_BIT = 2;
    localparam int KEY_REV_BIT = 3;
    localparam int KEY_STOP_BIT = 4;
    localparam int KEY_SIGNAL_BIT = 5;                // External switch signal level.

    // Status register bits.
    localparam int ST_MODE_LSB = 0;                   // Two-bit active mode.
    localparam int ST_FREQ_PANEL_BIT = 2;
    localparam int ST_START_PANEL_BIT = 3;
    localparam int ST_RUN_BIT = 4;
    localparam int ST_FWD_LAMP_BIT = 5;
    localparam int ST_REV_LAMP_BIT = 6;
    localparam int ST_REJECT_BIT = 7;

    // Mode-selection codes.
    localparam logic [3:0] SEL_SELECTABLE = 4'h0;
    localparam logic [3:0] SEL_PANEL_ONLY = 4'h1;
    localparam logic [3:0] SEL_EXT_ONLY = 4'h2;
    localparam logic [3:0] SEL_COMBO_PANEL_FREQ = 4'h3;
    localparam logic [3:0] SEL_COMBO_PANEL_START = 4'h4;
    localparam logic [3:0] SEL_SWITCH_OVER = 4'h6;
    localparam logic [3:0] SEL_EDIT_ENABLE = 4'h7;
    localparam logic [3:0] SEL_EXT_SIGNAL = 4'h8;

    typedef enum logic [1:0] {
        MODE_EXTERNAL,
        MODE_PANEL,
        MODE_COMBINED
    } opMode_t;

    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

endpackage

// ===== verilog/start_input_sync.sv
// Two-flop synchroniser for the forward and reverse start terminals.
// Assumes the terminals are active when shorted to the input common, seen low here.
`timescale 1ns/100ps
module start_input_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Raw terminals, low when closed to the common
    input wire logic fwdStartN,
    input wire logic revStartN,
    // Synchronised active-high levels
    start_sync_if.src syncOut
);
    logic [1:0] meta_r;
    logic [1:0] stable_r;

    // Only the second stage is read outside; the first feeds it alone.
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_r <= 2'b00;
            stable_r <= 2'b00;
        end else begin
            meta_r <= {~revStartN, ~fwdStartN};
            stable_r <= meta_r;
        end
    end

    assign syncOut.forward_run_key = stable_r[0];
    assign syncOut.reverse_run_key = stable_r[1];
endmodule

// ===== verilog/start_sync_if.sv
// Interface carrying the synchronised start inputs between modules.
// Assumes both ends share the single system clock.
`timescale 1ns/100ps
interface start_sync_if;
    logic forward_run_key;
    logic reverse_run_key;
    modport src (output forward_run_key, output reverse_run_key);
    modport dst (input forward_run_key, input reverse_run_key);
endinterface
